// ===== hw/tas_map.vh
`ifndef TAS_MAP_VH
`define TAS_MAP_VH
// ----------------------------------------
// special-register numbers of the assist set
// ----------------------------------------
`define TAS_SPR_SELECT 10'h270
`define TAS_SPR_EPAGE 10'h272
`define TAS_SPR_RPAGE 10'h273
`define TAS_SPR_DEFAULTS 10'h274
`define TAS_SPR_HVSEARCH 10'h153
// ----------------------------------------
// writable bits; all others are reserved
// ----------------------------------------
`define TAS_SELECT_MASK 32'h3fff_0fff
`define TAS_EPAGE_MASK 64'hffff_ffff_ffff_f0ff
`define TAS_RPAGE_MASK 32'hffff_f3ff
`define TAS_DEFAULTS_MASK 32'h3000_0f7f
`define TAS_HVSEARCH_MASK 32'h8000_0fff
`define TAS_RESET32 32'h0000_0000
`define TAS_RESET64 64'h0000_0000_0000_0000
// ----------------------------------------
// field positions (bit 0 is the lsb)
// ----------------------------------------
`define TAS_F_ARRAY 29:28
`define TAS_F_ENTRY 27:16
`define TAS_F_VICTIM 11:0
`define TAS_F_EPN 63:12
`define TAS_F_ACM 7:6
`define TAS_F_ATTR 5:0
`define TAS_F_RPN 31:12
`define TAS_F_USER 9:6
`define TAS_F_PERM 5:0
`define TAS_F_DSIZE 11:8
`define TAS_B_DACM 6
`define TAS_B_SGS 31
`define TAS_F_SEARCH_PARTITION_ID 11:0
// ----------------------------------------
// configuration
// ----------------------------------------
`define TAS_LPID_WIDTH 4'd12
`endif

// ===== hw/tas_epn_mask.v
`timescale 1ns/1ns
`include "tas_map.vh"
module tas_epn_mask (
  // page number and its size code
  input wire [51:0] epnIn,
  input wire [3:0] sizeCode,
  // page number with in-page offset bits cleared
  output wire [51:0] epnOut
);
  // size code n means a page of 4 to the n kilobytes
  wire [4:0] clearBits;
  wire [51:0] keepMask;
  assign clearBits = (sizeCode == 4'h0) ? 5'h00 : ({sizeCode, 1'b0} - 5'h02);
  assign keepMask = {52{1'b1}} << clearBits;
  assign epnOut = epnIn & keepMask;
endmodule // tas_epn_mask

// ===== hw/tas_part_match.v
`timescale 1ns/1ns
`include "tas_map.vh"
module tas_part_match (
  // guest space compare, used only when enabled
  input wire checkGuest,
  input wire searchGuest,
  input wire entryGuest,
  // partition identifiers
  input wire [11:0] searchPartition,
  input wire [11:0] entryPartition,
  // compare result
  output wire match
);
  // only the configured low bits of the identifier exist
  wire [11:0] widthMask;
  wire [11:0] entryBits;
  wire guestOk;
  assign widthMask = ~(12'hfff << `TAS_LPID_WIDTH);
  assign entryBits = entryPartition & widthMask;
  assign guestOk = !checkGuest || (searchGuest == entryGuest);
  // entry identifier zero is global and matches every partition
  assign match = guestOk &&
    ((entryBits == 12'h000) || (entryBits == (searchPartition & widthMask)));
endmodule // tas_part_match

// ===== hw/tas_assist.v
`timescale 1ns/1ns
`include "tas_map.vh"
// Function
// - entry read copies selected entry into registers
// - entry write stores registers into selected entry
// - misses and searches update registers by hardware
// - search context needs hypervisor; others supervisor
// - high real page register omitted, 32-bit
// - two-bit array select picks arrays 0-3
// - entry select updated on miss and search
// - victim updated on miss, search, read
// - no victim tracking leaves victim undefined
// - page number ignores offset bits per size
// - coherency domain ignored unless coherence set
// - variable-length plus endian fetch raises fault
// - low real page holds address bits 32-51
// - four user bits stored per entry
// - six execute/write/read permission bits
// - miss loads array select from default
// - miss loads translation size from default
// - miss loads page attributes from defaults
// - search compares guest state with entry
// - search/invalidate compare partition identifier
// - partition width constant; zero means none
module tas_assist (
  // clock and reset
  input wire clock,
  input wire rst,
  // special-register moves
  input wire sprWrite,
  input wire sprRead,
  input wire [9:0] sprNum,
  input wire [63:0] sprWdata,
  input wire supervisorState,
  input wire hypervisorState,
  output reg [63:0] sprRdata,
  output reg sprFault,
  // tlb instructions
  input wire instrRead,
  input wire instrWrite,
  input wire instrSearch,
  output reg instrDone,
  // miss preload
  input wire missEvent,
  input wire [51:0] missEpn,
  input wire [11:0] missVictim,
  input wire [11:0] missNextVictim,
  input wire missHasVictim,
  // requests to the arrays
  output reg tlbReadReq,
  output reg tlbWriteReq,
  output reg tlbSearchReq,
  output reg [1:0] tlbArraySel,
  output reg [11:0] tlbEntrySel,
  output reg [51:0] tlbEpn,
  output reg [7:0] tlbAttr,
  output reg [3:0] tlbSize,
  output reg [19:0] tlbRealPage,
  output reg [3:0] tlbUser,
  output reg [5:0] tlbPerm,
  output reg tlbSearchGuest,
  output reg [11:0] tlbSearchPartition,
  // answers from the arrays
  input wire tlbRespValid,
  input wire tlbRespHit,
  input wire [11:0] tlbRespWay,
  input wire [11:0] tlbRespVictim,
  input wire tlbRespHasVictim,
  input wire [51:0] tlbRespEpn,
  input wire [7:0] tlbRespAttr,
  input wire [3:0] tlbRespSize,
  input wire [19:0] tlbRespRealPage,
  input wire [3:0] tlbRespUser,
  input wire [5:0] tlbRespPerm,
  input wire tlbRespGuest,
  input wire [11:0] tlbRespPartition,
  // local invalidation compare
  input wire invalCheck,
  input wire [11:0] invalPartition,
  output reg invalMatch,
  // fetch attribute check
  input wire fetchValid,
  input wire fetchVle,
  input wire fetchEndian,
  input wire fetchCoherent,
  input wire [1:0] fetchAcm,
  input wire byteOrderClear,
  output reg fetchVariableLength,
  output reg [1:0] fetchCoherencyDomain,
  output reg byteOrderFault,
  output reg byteOrderStatus
);
  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_READ = 4'b0010;
  localparam ST_WRITE = 4'b0100;
  localparam ST_SEARCH = 4'b1000;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [31:0] select_reg;
  reg [31:0] select_next;
  reg [63:0] epage_reg;
  reg [63:0] epage_next;
  reg [31:0] rpage_reg;
  reg [31:0] rpage_next;
  reg [31:0] defaults_reg;
  reg [31:0] defaults_next;
  reg [31:0] hvsearch_reg;
  reg [31:0] hvsearch_next;
  reg [3:0] size_reg;
  reg [3:0] size_next;
  wire [51:0] maskedEpn;
  wire searchMatch;
  wire invalHit;
  wire hvPresent;
  wire isSelect;
  wire isEpage;
  wire isRpage;
  wire isDefaults;
  wire isHv;
  wire mapped;
  wire accessOk;
  wire doWrite;
  wire respIn;
  wire searchHit;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // offset bits dropped
  tas_epn_mask u_epn (
    .epnIn(epage_reg[`TAS_F_EPN]),
    .sizeCode(size_reg),
    .epnOut(maskedEpn)
  );
  tas_part_match u_search (
    .checkGuest(1'b1),
    .searchGuest(hvsearch_reg[`TAS_B_SGS]),
    .entryGuest(tlbRespGuest),
    .searchPartition(hvsearch_reg[`TAS_F_SEARCH_PARTITION_ID]),
    .entryPartition(tlbRespPartition),
    .match(searchMatch)
  );
  tas_part_match u_inval (
    .checkGuest(1'b0),
    .searchGuest(1'b0),
    .entryGuest(1'b0),
    .searchPartition(hvsearch_reg[`TAS_F_SEARCH_PARTITION_ID]),
    .entryPartition(invalPartition),
    .match(invalHit)
  );
  // ----------------------------------------
  // access decode
  // ----------------------------------------
  // zero width means no hypervisor support
  assign hvPresent = (`TAS_LPID_WIDTH != 4'd0);
  assign isSelect = (sprNum == `TAS_SPR_SELECT);
  assign isEpage = (sprNum == `TAS_SPR_EPAGE);
  assign isRpage = (sprNum == `TAS_SPR_RPAGE);
  assign isDefaults = (sprNum == `TAS_SPR_DEFAULTS);
  assign isHv = (sprNum == `TAS_SPR_HVSEARCH) && hvPresent;
  assign mapped = isSelect || isEpage || isRpage || isDefaults || isHv;
  assign accessOk = supervisorState && (!isHv || hypervisorState);
  assign doWrite = sprWrite && mapped && accessOk;
  assign respIn = tlbRespValid && (state_reg != ST_IDLE);
  assign searchHit = tlbRespHit && searchMatch;
  // ----------------------------------------
  // register next values
  // ----------------------------------------
  // software writes first; hardware updates of the same cycle override them
  always @* begin
    select_next = select_reg;
    epage_next = epage_reg;
    rpage_next = rpage_reg;
    defaults_next = defaults_reg;
    hvsearch_next = hvsearch_reg;
    size_next = size_reg;
    if (doWrite && isSelect) begin
      select_next = sprWdata[31:0] & `TAS_SELECT_MASK;
    end
    if (doWrite && isEpage) begin
      epage_next = sprWdata & `TAS_EPAGE_MASK;
    end
    if (doWrite && isRpage) begin
      rpage_next = sprWdata[31:0] & `TAS_RPAGE_MASK;
    end
    if (doWrite && isDefaults) begin
      defaults_next = sprWdata[31:0] & `TAS_DEFAULTS_MASK;
    end
    if (doWrite && isHv) begin
      hvsearch_next = sprWdata[31:0] & `TAS_HVSEARCH_MASK;
    end
    // entry contents copied in on read or search hit
    if (respIn && (state_reg[1] || (state_reg[3] && searchHit))) begin
      epage_next[`TAS_F_EPN] = tlbRespEpn;
      epage_next[7:0] = tlbRespAttr;
      size_next = tlbRespSize;
      rpage_next[`TAS_F_RPN] = tlbRespRealPage;
      rpage_next[`TAS_F_USER] = tlbRespUser;
      rpage_next[`TAS_F_PERM] = tlbRespPerm;
    end
    if (respIn && state_reg[3]) begin
      select_next[`TAS_F_ENTRY] = searchHit ? tlbRespWay : tlbRespVictim;
    end
    // victim refreshed only by arrays that track it
    // otherwise left as is, contents undefined
    if (respIn && (state_reg[1] || state_reg[3]) && tlbRespHasVictim) begin
      select_next[`TAS_F_VICTIM] = tlbRespVictim;
    end
    if (missEvent) begin
      select_next[`TAS_F_ARRAY] = defaults_reg[`TAS_F_ARRAY];
      select_next[`TAS_F_ENTRY] = missVictim;
      if (missHasVictim) begin
        select_next[`TAS_F_VICTIM] = missNextVictim;
      end
      epage_next[`TAS_F_EPN] = missEpn;
      size_next = defaults_reg[`TAS_F_DSIZE];
      epage_next[`TAS_F_ACM] = {1'b0, defaults_reg[`TAS_B_DACM]};
      epage_next[`TAS_F_ATTR] = defaults_reg[`TAS_F_ATTR];
    end
  end
  // ----------------------------------------
  // instruction sequencer
  // ----------------------------------------
  // one instruction at a time; new ones are ignored until the arrays answer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (instrRead) begin
          state_next = ST_READ;
        end else if (instrWrite) begin
          state_next = ST_WRITE;
        end else if (instrSearch) begin
          state_next = ST_SEARCH;
        end
      end
      ST_READ, ST_WRITE, ST_SEARCH: begin
        if (tlbRespValid) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end
  // ----------------------------------------
  // clocked storage
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      select_reg <= `TAS_RESET32;
      epage_reg <= `TAS_RESET64;
      rpage_reg <= `TAS_RESET32;
      defaults_reg <= `TAS_RESET32;
      hvsearch_reg <= `TAS_RESET32;
      size_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      select_reg <= select_next;
      epage_reg <= epage_next;
      rpage_reg <= rpage_next;
      defaults_reg <= defaults_next;
      hvsearch_reg <= hvsearch_next;
      size_reg <= size_next;
    end
  end
  // ----------------------------------------
  // special-register read port
  // ----------------------------------------
  // unmapped and reserved bits answer zero
  always @(posedge clock) begin
    if (rst) begin
      sprRdata <= `TAS_RESET64;
      sprFault <= 1'b0;
    end else begin
      sprFault <= (sprRead || sprWrite) && mapped && !accessOk;
      if (sprRead) begin
        sprRdata <= `TAS_RESET64;
        if (accessOk && isSelect) begin
          sprRdata <= {32'h0000_0000, select_reg};
        end
        if (accessOk && isEpage) begin
          sprRdata <= epage_reg;
        end
        if (accessOk && isRpage) begin
          sprRdata <= {32'h0000_0000, rpage_reg};
        end
        if (accessOk && isDefaults) begin
          sprRdata <= {32'h0000_0000, defaults_reg};
        end
        if (accessOk && isHv) begin
          sprRdata <= {32'h0000_0000, hvsearch_reg};
        end
      end
    end
  end
  // ----------------------------------------
  // array requests
  // ----------------------------------------
  // fields are captured at launch so they stay steady while the array works
  always @(posedge clock) begin
    if (rst) begin
      tlbReadReq <= 1'b0;
      tlbWriteReq <= 1'b0;
      tlbSearchReq <= 1'b0;
      tlbArraySel <= 2'h0;
      tlbEntrySel <= 12'h000;
      tlbEpn <= 52'h0_0000_0000_0000;
      tlbAttr <= 8'h00;
      tlbSize <= 4'h0;
      tlbRealPage <= 20'h0_0000;
      tlbUser <= 4'h0;
      tlbPerm <= 6'h00;
      tlbSearchGuest <= 1'b0;
      tlbSearchPartition <= 12'h000;
      instrDone <= 1'b0;
      invalMatch <= 1'b0;
    end else begin
      tlbReadReq <= state_reg[0] && state_next[1];
      tlbWriteReq <= state_reg[0] && state_next[2];
      tlbSearchReq <= state_reg[0] && state_next[3];
      instrDone <= respIn;
      invalMatch <= invalCheck && invalHit;
      if (state_reg[0] && !state_next[0]) begin
        tlbArraySel <= select_reg[`TAS_F_ARRAY];
        // software keeps entry select in range
        tlbEntrySel <= select_reg[`TAS_F_ENTRY];
        tlbEpn <= maskedEpn;
        tlbAttr <= epage_reg[7:0];
        tlbSize <= size_reg;
        // no upper real page, 32-bit addresses
        tlbRealPage <= rpage_reg[`TAS_F_RPN];
        tlbUser <= rpage_reg[`TAS_F_USER];
        tlbPerm <= rpage_reg[`TAS_F_PERM];
        tlbSearchGuest <= hvsearch_reg[`TAS_B_SGS];
        tlbSearchPartition <= hvsearch_reg[`TAS_F_SEARCH_PARTITION_ID];
      end
    end
  end
  // ----------------------------------------
  // fetch attribute check
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      fetchVariableLength <= 1'b0;
      fetchCoherencyDomain <= 2'h0;
      byteOrderFault <= 1'b0;
      byteOrderStatus <= 1'b0;
    end else begin
      fetchVariableLength <= fetchValid && fetchVle && !fetchEndian;
      byteOrderFault <= fetchValid && fetchVle && fetchEndian;
      // a new fault wins over a clear in the same cycle
      if (fetchValid && fetchVle && fetchEndian) begin
        byteOrderStatus <= 1'b1;
      end else if (byteOrderClear) begin
        byteOrderStatus <= 1'b0;
      end
      fetchCoherencyDomain <= fetchCoherent ? fetchAcm : 2'h0;
    end
  end
endmodule // tas_assist

// ===== verification/tas_assist_sva.sv
`timescale 1ns/1ns
`include "tas_map.vh"
module tas_assist_sva (
  // clock and reset
  input wire clock,
  input wire rst,
  // register moves
  input wire sprWrite,
  input wire sprRead,
  input wire [9:0] sprNum,
  input wire supervisorState,
  input wire hypervisorState,
  input wire [63:0] sprRdata,
  input wire sprFault,
  // instructions
  input wire instrRead,
  input wire instrDone,
  input wire tlbReadReq,
  input wire tlbWriteReq,
  input wire tlbSearchReq,
  input wire tlbRespValid,
  // miss preload
  input wire missEvent,
  input wire [11:0] missVictim,
  input wire [11:0] missNextVictim,
  input wire missHasVictim,
  // fetch check
  input wire fetchValid,
  input wire fetchVle,
  input wire fetchEndian,
  input wire byteOrderClear,
  input wire byteOrderFault,
  input wire byteOrderStatus
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // one instruction in flight at most, so a single flag tracks it
  reg pend;
  wire anyReq = tlbReadReq | tlbWriteReq | tlbSearchReq;
  wire anySpr = sprRead | sprWrite;
  wire selRead = sprRead && sprNum == `TAS_SPR_SELECT && supervisorState;
  always @(posedge clock) begin
    if (rst)
      pend <= 1'b0;
    else if (anyReq)
      pend <= 1'b1;
    else if (instrDone)
      pend <= 1'b0;
  end
  chk_read_launch: assert property (instrRead && !pend && !anyReq |=> tlbReadReq)
    else $error("entry read not launched");
  chk_done_answer: assert property (tlbRespValid && pend |=> instrDone)
    else $error("done missing after answer");
  chk_done_cause: assert property (instrDone |-> $past(tlbRespValid))
    else $error("done without answer");
  chk_hv_refused: assert property (anySpr && sprNum == `TAS_SPR_HVSEARCH
    && !hypervisorState |=> sprFault) else $error("hypervisor register not refused");
  chk_select_open: assert property (anySpr && sprNum == `TAS_SPR_SELECT
    && supervisorState |=> !sprFault) else $error("supervisor access refused");
  chk_miss_entry: assert property (missEvent ##2 selRead
    |=> sprRdata[27:16] == $past(missVictim, 3)) else $error("entry select not preloaded");
  chk_miss_victim: assert property (missEvent && missHasVictim ##2 selRead
    |=> sprRdata[11:0] == $past(missNextVictim, 3)) else $error("victim not preloaded");
  chk_bo_raise: assert property (fetchValid && fetchVle && fetchEndian
    |=> byteOrderFault && byteOrderStatus) else $error("byte order fault missing");
  chk_bo_cause: assert property (byteOrderFault |-> $past(fetchVle) && $past(fetchEndian))
    else $error("byte order fault without cause");
  chk_bo_sticky: assert property (byteOrderStatus && !byteOrderClear |=> byteOrderStatus)
    else $error("byte order status lost");
endmodule // tas_assist_sva
bind tas_assist tas_assist_sva chk (.*);

// ===== verification/tas_array_model.sv
`timescale 1ns/1ns
module tas_array_model (
  // clock, reset and answer delay
  input wire clock,
  input wire rst,
  input wire [3:0] lat,
  input wire hasVictim,
  // requests
  input wire tlbReadReq,
  input wire tlbWriteReq,
  input wire tlbSearchReq,
  input wire [11:0] tlbEntrySel,
  input wire [51:0] tlbEpn,
  input wire [7:0] tlbAttr,
  input wire [3:0] tlbSize,
  input wire [19:0] tlbRealPage,
  input wire [3:0] tlbUser,
  input wire [5:0] tlbPerm,
  // answers
  output reg tlbRespValid,
  output wire tlbRespHit,
  output wire [11:0] tlbRespWay,
  output wire [11:0] tlbRespVictim,
  output wire tlbRespHasVictim,
  output wire [51:0] tlbRespEpn,
  output wire [7:0] tlbRespAttr,
  output wire [3:0] tlbRespSize,
  output wire [19:0] tlbRespRealPage,
  output wire [3:0] tlbRespUser,
  output wire [5:0] tlbRespPerm,
  output wire tlbRespGuest,
  output wire [11:0] tlbRespPartition
);
  // four ways only; entries are global, hypervisor space
  reg [93:0] mem [0:3];
  reg [132:0] ans;
  reg [3:0] cnt;
  reg busy;
  integer i;
  wire [93:0] ent = {tlbEpn, tlbAttr, tlbSize, tlbRealPage, tlbUser, tlbPerm};
  wire [11:0] vic = {10'h000, tlbEntrySel[1:0] + 2'h1};
  // fields are garbage outside the valid cycle, never a stale copy
  assign {tlbRespEpn, tlbRespAttr, tlbRespSize, tlbRespRealPage, tlbRespUser, tlbRespPerm,
    tlbRespGuest, tlbRespPartition, tlbRespHit, tlbRespWay, tlbRespVictim,
    tlbRespHasVictim} = tlbRespValid ? ans : ~ans;
  // answer is worked out at launch and released lat+1 cycles later
  always @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
      tlbRespValid <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        mem[i] <= 94'h0;
    end else begin
      tlbRespValid <= 1'b0;
      if (tlbReadReq || tlbWriteReq || tlbSearchReq) begin
        busy <= 1'b1;
        cnt <= lat;
        ans <= {mem[tlbEntrySel[1:0]], 13'h0, 1'b0, tlbEntrySel, vic, hasVictim};
        if (tlbWriteReq)
          mem[tlbEntrySel[1:0]] <= ent;
        for (i = 0; tlbSearchReq && i < 4; i = i + 1)
          if (mem[i][93:42] == tlbEpn)
            ans <= {mem[i], 13'h0, 1'b1, i[11:0], vic, hasVictim};
      end else if (busy && cnt == 4'h0) begin
        tlbRespValid <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // tas_array_model

// ===== verification/tb.sv
`timescale 1ns/1ns
`include "tas_map.vh"
module tb;
  logic clock, rst, sprWrite, sprRead, supervisorState, hypervisorState, sprFault, flt;
  logic instrRead, instrWrite, instrSearch, instrDone, tlbReadReq, tlbWriteReq, tlbSearchReq;
  logic missEvent, missHasVictim, invalCheck, invalMatch, hasVictim, tlbRespValid, tlbRespHit;
  logic fetchValid, fetchVle, fetchEndian, fetchCoherent, byteOrderClear, fetchVariableLength;
  logic byteOrderFault, byteOrderStatus, tlbSearchGuest, tlbRespHasVictim, tlbRespGuest;
  logic [1:0] tlbArraySel, fetchAcm, fetchCoherencyDomain;
  logic [3:0] lat, tlbSize, tlbUser, tlbRespSize, tlbRespUser;
  logic [5:0] tlbPerm, tlbRespPerm;
  logic [7:0] tlbAttr, tlbRespAttr;
  logic [9:0] sprNum;
  logic [11:0] missVictim, missNextVictim, tlbEntrySel, tlbSearchPartition, invalPartition;
  logic [11:0] tlbRespWay, tlbRespVictim, tlbRespPartition;
  logic [19:0] tlbRealPage, tlbRespRealPage;
  logic [51:0] missEpn, tlbEpn, tlbRespEpn;
  logic [63:0] sprWdata, sprRdata, rd;
  logic [73:0] ri;
  integer err_count, n_tests, k, j;
  tas_assist DUT (.*);
  tas_array_model partner (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task chk(input [63:0] got, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // one register move; read data and fault land one cycle later
  // idle cycle after each move
  task spr(input wr, input [9:0] n, input [63:0] d);
    begin
      @(posedge clock);
      sprWrite <= wr;
      sprRead <= !wr;
      sprNum <= n;
      sprWdata <= d;
      @(posedge clock);
      sprWrite <= 1'b0;
      sprRead <= 1'b0;
      #1 rd = sprRdata;
      flt = sprFault;
    end
  endtask
  // kind 0 read, 1 write, 2 search; waits for done, bounded
  task instr(input [1:0] kind, input [3:0] l);
    begin
      @(posedge clock);
      lat <= l;
      instrRead <= kind == 2'h0;
      instrWrite <= kind == 2'h1;
      instrSearch <= kind == 2'h2;
      @(posedge clock);
      {instrRead, instrWrite, instrSearch} <= 3'h0;
      for (j = 0; j < 40 && instrDone !== 1'b1; j = j + 1)
        @(posedge clock) #1;
      if (instrDone !== 1'b1) begin
        chk(instrDone, 64'h1);
        final_report;
      end
    end
  endtask
  function [73:0] regInfo(input integer i);
    case (i)
      0: regInfo = {`TAS_SPR_SELECT, 32'h0, `TAS_SELECT_MASK};
      1: regInfo = {`TAS_SPR_EPAGE, `TAS_EPAGE_MASK};
      2: regInfo = {`TAS_SPR_RPAGE, 32'h0, `TAS_RPAGE_MASK};
      3: regInfo = {`TAS_SPR_DEFAULTS, 32'h0, `TAS_DEFAULTS_MASK};
      default: regInfo = {`TAS_SPR_HVSEARCH, 32'h0, `TAS_HVSEARCH_MASK};
    endcase
  endfunction
  task t_regs;
    begin
      for (k = 0; k < 5; k = k + 1) begin
        ri = regInfo(k);
        spr(1'b0, ri[73:64], 64'h0);
        chk(rd, 64'h0);
        spr(1'b1, ri[73:64], 64'hffff_ffff_ffff_ffff);
        spr(1'b0, ri[73:64], 64'h0);
        chk(rd, ri[63:0]);
      end
      spr(1'b1, `TAS_SPR_HVSEARCH, 64'h0);
      @(posedge clock);
      hypervisorState <= 1'b0;
      spr(1'b1, `TAS_SPR_HVSEARCH, 64'h1);
      chk(flt, 64'h1);
      spr(1'b0, `TAS_SPR_SELECT, 64'h0);
      chk(rd, 64'h3fff_0fff);
      chk(flt, 64'h0);
      @(posedge clock);
      supervisorState <= 1'b0;
      spr(1'b0, `TAS_SPR_SELECT, 64'h0);
      chk(rd, 64'h0);
      chk(flt, 64'h1);
      @(posedge clock);
      {supervisorState, hypervisorState} <= 2'h3;
      spr(1'b0, `TAS_SPR_HVSEARCH, 64'h0);
      chk(rd, 64'h0);
      spr(1'b0, 10'h3ff, 64'h0);
      chk({rd, flt}, {64'h0, 1'b0});
      $display("test registers finished");
    end
  endtask
  task t_miss;
    begin
      spr(1'b1, `TAS_SPR_DEFAULTS, 64'h3000_027f);
      @(posedge clock);
      {missEvent, missHasVictim} <= 2'h3;
      missEpn <= 52'h12345;
      missVictim <= 12'h005;
      missNextVictim <= 12'h006;
      @(posedge clock);
      missEvent <= 1'b0;
      spr(1'b0, `TAS_SPR_SELECT, 64'h0);
      chk(rd, 64'h3005_0006);
      spr(1'b0, `TAS_SPR_EPAGE, 64'h0);
      chk(rd[7:0], 8'h7f);
      $display("test miss preload finished");
    end
  endtask
  task t_entry;
    begin
      spr(1'b1, `TAS_SPR_SELECT, 64'h2001_0000);
      spr(1'b1, `TAS_SPR_EPAGE, 64'h1234_5025);
      spr(1'b1, `TAS_SPR_RPAGE, 64'habcd_e2a5);
      instr(2'h1, 4'h0);
      chk({tlbArraySel, tlbEntrySel, tlbRealPage, tlbUser, tlbPerm},
        {2'h2, 12'h001, 20'habcde, 4'ha, 6'h25});
      chk({tlbEpn, tlbAttr, tlbSize}, {52'h1_2344, 8'h25, 4'h2});
      spr(1'b1, `TAS_SPR_RPAGE, 64'h0);
      instr(2'h0, 4'h6);
      spr(1'b0, `TAS_SPR_RPAGE, 64'h0);
      chk(rd, 64'habcd_e2a5);
      spr(1'b0, `TAS_SPR_SELECT, 64'h0);
      chk(rd, 64'h2001_0002);
      $display("test entry write and read finished");
    end
  endtask
  task t_search;
    begin
      spr(1'b1, `TAS_SPR_SELECT, 64'h2003_0000);
      instr(2'h2, 4'h2);
      spr(1'b0, `TAS_SPR_SELECT, 64'h0);
      chk(rd[27:0], 28'h001_0000);
      spr(1'b1, `TAS_SPR_EPAGE, 64'h5555_5000);
      spr(1'b1, `TAS_SPR_SELECT, 64'h2003_0000);
      instr(2'h2, 4'h1);
      spr(1'b0, `TAS_SPR_SELECT, 64'h0);
      chk(rd[27:0], 28'h000_0000);
      spr(1'b1, `TAS_SPR_HVSEARCH, 64'h8000_0000);
      spr(1'b1, `TAS_SPR_EPAGE, 64'h1234_5000);
      spr(1'b1, `TAS_SPR_SELECT, 64'h2003_0000);
      instr(2'h2, 4'h1);
      chk({tlbSearchGuest, tlbSearchPartition}, 64'h1000);
      spr(1'b0, `TAS_SPR_SELECT, 64'h0);
      chk(rd[27:0], 28'h000_0000);
      $display("test search finished");
    end
  endtask
  task t_fetch;
    begin
      @(posedge clock);
      {fetchValid, fetchVle, fetchEndian, fetchCoherent, invalCheck} <= 5'h1f;
      fetchAcm <= 2'h2;
      invalPartition <= 12'h000;
      @(posedge clock);
      fetchEndian <= 1'b0;
      invalPartition <= 12'h005;
      #1 chk({byteOrderStatus, byteOrderFault, fetchVariableLength}, 64'h6);
      chk(fetchCoherencyDomain, 64'h2);
      chk(invalMatch, 64'h1);
      @(posedge clock);
      {fetchCoherent, byteOrderClear, invalCheck} <= 3'h2;
      #1 chk({byteOrderStatus, byteOrderFault, fetchVariableLength}, 64'h5);
      chk(invalMatch, 64'h0);
      @(posedge clock);
      {fetchValid, fetchVle, byteOrderClear} <= 3'h0;
      #1 chk({byteOrderStatus, fetchCoherencyDomain}, 64'h0);
      $display("test fetch attributes finished");
    end
  endtask
  initial begin
    err_count = 0;
    n_tests = 0;
    {rst, hasVictim, sprWrite, sprRead, instrRead, instrWrite, instrSearch, missEvent} = 8'hc0;
    {missHasVictim, invalCheck, fetchValid, fetchVle, fetchEndian, fetchCoherent} = 6'h00;
    {supervisorState, hypervisorState, byteOrderClear} = 3'h6;
    {sprNum, sprWdata, missEpn, missVictim, missNextVictim, invalPartition} = 162'h0;
    {fetchAcm, lat} = 6'h00;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_miss;
    t_entry;
    t_search;
    t_fetch;
    final_report;
  end
endmodule // tb
